// File: rtl/lmd_pkg.sv
// constants, field layouts and reset values of the matrix dimming core
// assumes a 250 MHz system clock and an AXI4-Lite register master
package lmd_pkg;
  localparam int NLINE = 6;
  localparam int NSINK = 18;
  localparam int NDOT  = NLINE * NSINK;
  localparam int NGRP  = 3;

  // register byte offsets
  localparam logic [11:0] OFS_CTRL  = 12'h000;
  localparam logic [11:0] OFS_LEVEL = 12'h004;
  localparam logic [11:0] OFS_COLOR = 12'h008;
  localparam logic [11:0] OFS_GROUP = 12'h00C;
  localparam logic [11:0] OFS_PTR   = 12'h010;
  localparam logic [11:0] OFS_DATA  = 12'h014;
  localparam logic [11:0] OFS_STAT  = 12'h018;

  // control and level field positions
  localparam int CTRL_MODE  = 0;
  localparam int CTRL_SLOW  = 2;
  localparam int CTRL_PHASE = 3;
  localparam int CTRL_DLY   = 4;
  localparam int CTRL_EXPO  = 5;
  localparam int CTRL_LINES = 8;
  localparam int LVL_GLB    = 0;
  localparam int LVL_MAXC   = 8;

  // reset values
  localparam logic [1:0] MODE_RST  = 2'h1;
  localparam logic [2:0] LINES_RST = 3'h5;
  localparam logic [2:0] MAXC_RST  = 3'h3;
  localparam logic [7:0] GLB_RST   = 8'hFF;
  localparam logic [6:0] CC_RST    = 7'h40;
  localparam logic [7:0] GDU_RST   = 8'hFF;
  localparam logic [7:0] DGAIN_RST = 8'h80;

  // display memory byte windows
  localparam logic [9:0] GAIN_BASE  = 10'h000;
  localparam logic [9:0] D8_BASE    = 10'h080;
  localparam logic [9:0] D16_BASE   = 10'h100;
  localparam logic [9:0] GSEL_BASE  = 10'h200;
  localparam int         GSEL_BYTES = 30;
  localparam logic [9:0] ONOFF_BASE = 10'h220;
  localparam int         ONOFF_BYTES = 18;

  // refresh modes
  typedef enum logic [1:0] {
    LMD_MODE_OFF  = 2'b00,
    LMD_MODE_IMM  = 2'b01,
    LMD_MODE_FR8  = 2'b10,
    LMD_MODE_FR16 = 2'b11
  } lmd_mode_t;

  // timing
  localparam int CLK_KHZ     = 250000;
  localparam int OSC_KHZ     = 31200;
  localparam logic [11:0] OSC_STEP = 12'(OSC_KHZ / 100);
  localparam logic [11:0] OSC_MOD  = 12'(CLK_KHZ / 100);
  localparam int PWM_NS_FAST = 8000;
  localparam int PWM_NS_SLOW = 16000;
  localparam int BLANK_NS    = 1000;
  localparam int PHASE_NS    = 125;
  localparam int DLY_PS_FAST = 62500;
  localparam int DLY_PS_SLOW = 31250;
  localparam logic [9:0] PWM_TK_FAST = 10'(PWM_NS_FAST * OSC_KHZ / 1000000);
  localparam logic [9:0] PWM_TK_SLOW = 10'(PWM_NS_SLOW * OSC_KHZ / 1000000);
  localparam logic [9:0] BLANK_TK    = 10'(BLANK_NS * OSC_KHZ / 1000000);
  localparam logic [9:0] PHASE_TK =
    10'((PHASE_NS * OSC_KHZ + 999999) / 1000000);
  // divide the product by 1000 before rounding so the rounding sum stays inside a 32-bit int
  localparam logic [9:0] DLY_TK_FAST =
    10'((DLY_PS_FAST * OSC_KHZ / 1000 + 999999) / 1000000);
  localparam logic [9:0] DLY_TK_SLOW =
    10'((DLY_PS_SLOW * OSC_KHZ / 1000 + 999999) / 1000000);

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : lmd_pkg

// File: rtl/lmd_core.sv
// matrix dimming and refresh core with AXI4-Lite register access
// assumes synchronous inputs on clk_sys, frame pulses from the host
module lmd_core (
  input  wire logic                    clk_sys,
  input  wire logic                    rst_n,
  input  wire logic                    ce,
  input  wire logic                    frame_sync,
  input  wire logic [11:0]             s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [11:0]             s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  output logic [lmd_pkg::NLINE-1:0]    line_on,
  output logic [lmd_pkg::NSINK-1:0]    sink_on,
  output logic [lmd_pkg::NSINK*15-1:0] sink_gain,
  output logic [2:0]                   max_current
);
  import lmd_pkg::*;

  typedef struct packed {
    logic [1:0]                  mode;
    logic                        slow;
    logic                        phase_en;
    logic                        dly_en;
    logic                        expo;
    logic [2:0]                  lines_m1;
    logic [2:0]                  maxc;
    logic [7:0]                  glb;
    logic [NGRP-1:0][6:0]        cc;
    logic [NGRP-1:0][7:0]        gdu;
    logic [9:0]                  ptr;
    logic [NDOT-1:0][7:0]        dgain;
    logic [NDOT-1:0][7:0]        duty8;
    logic [NDOT-1:0][7:0]        disp8;
    logic [NDOT-1:0][15:0]       duty16;
    logic [NDOT-1:0][15:0]       disp16;
    logic [NDOT-1:0][1:0]        gsel;
    logic [NDOT-1:0]             onoff;
    logic [11:0]                 acc;
    logic [9:0]                  tick;
    logic [2:0]                  line;
    logic                        sync_d;
    logic [15:0]                 frames;
    logic                        aw_h;
    logic [11:0]                 aw_a;
    logic                        w_h;
    logic [31:0]                 w_d;
    logic [3:0]                  w_s;
    logic                        awready;
    logic                        wready;
    logic                        bvalid;
    logic [1:0]                  bresp;
    logic                        arready;
    logic                        rvalid;
    logic [31:0]                 rdata;
    logic [1:0]                  rresp;
    logic [NLINE-1:0]            line_on;
    logic [NSINK-1:0]            sink_on;
    logic [NSINK-1:0][14:0]      sgain;
  } lmd_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic lmd_state_t reset_state();
    lmd_state_t s;
    s          = '0;
    s.mode     = MODE_RST;
    s.lines_m1 = LINES_RST;
    s.maxc     = MAXC_RST;
    s.glb      = GLB_RST;
    s.awready  = 1'b1;
    s.wready   = 1'b1;
    s.arready  = 1'b1;
    for (int g = 0; g < NGRP; g++) begin
      s.cc[g]  = CC_RST;
      s.gdu[g] = GDU_RST;
    end
    for (int d = 0; d < NDOT; d++) begin
      s.dgain[d] = DGAIN_RST;
    end
    return s;
  endfunction : reset_state

  localparam lmd_state_t RST_STATE = reset_state();

  // x/255 as a 9-bit fraction of 256, exact at both ends
  function automatic logic [8:0] frac255(input logic [7:0] x);
    return {1'b0, x} + {8'h00, x[7]};
  endfunction : frac255

  function automatic logic [15:0] duty_final(input logic [15:0] ind,
                                             input logic [7:0]  grp,
                                             input logic [7:0]  glb);
    logic [33:0] p;
    p = 34'(ind) * 34'(frac255(grp)) * 34'(frac255(glb));
    return p[31:16];
  endfunction : duty_final

  // fixed square-law curve for perceptual dimming
  function automatic logic [15:0] expo_curve(input logic [15:0] d);
    logic [31:0] p;
    p = 32'(d) * 32'(d);
    return p[31:16];
  endfunction : expo_curve

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic [7:0] rd_byte(input lmd_state_t s,
                                         input logic [9:0] p);
    logic [9:0] o;
    logic [7:0] r;
    int         d;
    r = 8'h00;
    if (p < 10'(NDOT)) begin
      r = s.dgain[p];
    end else if (p >= D8_BASE && p < D8_BASE + 10'(NDOT)) begin
      o = p - D8_BASE;
      r = s.duty8[o];
    end else if (p >= D16_BASE && p < D16_BASE + 10'(2 * NDOT)) begin
      o = p - D16_BASE;
      r = s.duty16[o[9:1]][o[0]*8 +: 8];
    end else if (p >= GSEL_BASE && p < GSEL_BASE + 10'(GSEL_BYTES)) begin
      o = p - GSEL_BASE;
      for (int j = 0; j < 4; j++) begin
        d = int'(o) * 4 + j;
        if (d < NDOT) begin
          r[j*2 +: 2] = s.gsel[d];
        end
      end
    end else if (p >= ONOFF_BASE && p < ONOFF_BASE + 10'(ONOFF_BYTES)) begin
      o = p - ONOFF_BASE;
      for (int j = 0; j < 6; j++) begin
        r[j] = s.onoff[int'(o) * 6 + j];
      end
    end
    return r;
  endfunction : rd_byte

  function automatic lmd_state_t wr_byte(input lmd_state_t s,
                                         input logic [9:0] p,
                                         input logic [7:0] b);
    logic [9:0] o;
    int         d;
    if (p < 10'(NDOT)) begin
      s.dgain[p] = b;
    end else if (p >= D8_BASE && p < D8_BASE + 10'(NDOT)) begin
      o = p - D8_BASE;
      s.duty8[o] = b;
    end else if (p >= D16_BASE && p < D16_BASE + 10'(2 * NDOT)) begin
      o = p - D16_BASE;
      s.duty16[o[9:1]][o[0]*8 +: 8] = b;
    end else if (p >= GSEL_BASE && p < GSEL_BASE + 10'(GSEL_BYTES)) begin
      o = p - GSEL_BASE;
      for (int j = 0; j < 4; j++) begin
        d = int'(o) * 4 + j;
        if (d < NDOT) begin
          s.gsel[d] = b[j*2 +: 2];
        end
      end
    end else if (p >= ONOFF_BASE && p < ONOFF_BASE + 10'(ONOFF_BYTES)) begin
      o = p - ONOFF_BASE;
      for (int j = 0; j < 6; j++) begin
        s.onoff[int'(o) * 6 + j] = b[j];
      end
    end
    return s;
  endfunction : wr_byte

  ////////////////////////////////////////////////////////////////////////////
  // state

  lmd_state_t r;
  lmd_state_t next_r;

  always_comb begin
    logic [9:0]  pwm_tk;
    logic [9:0]  line_tk;
    logic [9:0]  start;
    logic [9:0]  thr;
    logic [15:0] ind;
    logic [15:0] fin;
    logic [7:0]  d8;
    logic [7:0]  grp;
    logic [25:0] scaled;
    logic [31:0] wv;
    logic        tk;
    int          idx;
    next_r = r;
    pwm_tk  = 10'h000;
    line_tk = 10'h000;
    start   = 10'h000;
    thr     = 10'h000;
    ind     = 16'h0000;
    fin     = 16'h0000;
    d8      = 8'h00;
    grp     = 8'h00;
    scaled  = 26'h0000000;
    wv      = 32'h00000000;
    tk      = 1'b0;
    idx     = 0;

    // write channel
    if (s_axi_awvalid && r.awready) begin
      next_r.aw_h    = 1'b1;
      next_r.aw_a    = s_axi_awaddr;
    end
    if (s_axi_wvalid && r.wready) begin
      next_r.w_h     = 1'b1;
      next_r.w_d     = s_axi_wdata;
      next_r.w_s     = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_r.bvalid  = 1'b0;
    end
    if (r.aw_h && r.w_h && !r.bvalid) begin
      next_r.aw_h   = 1'b0;
      next_r.w_h    = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp  = RESP_OKAY;
      unique case ({r.aw_a[11:2], 2'b00})
        OFS_CTRL: begin
          wv = merge({21'h0, r.lines_m1, 2'b00, r.expo, r.dly_en,
                      r.phase_en, r.slow, r.mode}, r.w_d, r.w_s);
          next_r.mode     = wv[CTRL_MODE +: 2];
          next_r.slow     = wv[CTRL_SLOW];
          next_r.phase_en = wv[CTRL_PHASE];
          next_r.dly_en   = wv[CTRL_DLY];
          next_r.expo     = wv[CTRL_EXPO];
          next_r.lines_m1 = wv[CTRL_LINES +: 3];
        end
        OFS_LEVEL: begin
          wv = merge({21'h0, r.maxc, r.glb}, r.w_d, r.w_s);
          next_r.glb  = wv[LVL_GLB +: 8];
          next_r.maxc = wv[LVL_MAXC +: 3];
        end
        OFS_COLOR: begin
          wv = merge({8'h0, 1'b0, r.cc[2], 1'b0, r.cc[1], 1'b0, r.cc[0]},
                     r.w_d, r.w_s);
          for (int g = 0; g < NGRP; g++) begin
            next_r.cc[g] = wv[g*8 +: 7];
          end
        end
        OFS_GROUP: begin
          wv = merge({8'h0, r.gdu[2], r.gdu[1], r.gdu[0]}, r.w_d, r.w_s);
          for (int g = 0; g < NGRP; g++) begin
            next_r.gdu[g] = wv[g*8 +: 8];
          end
        end
        OFS_PTR: begin
          wv = merge({22'h0, r.ptr}, r.w_d, r.w_s);
          next_r.ptr = wv[9:0];
        end
        OFS_DATA: begin
          if (r.w_s[0]) begin
            next_r     = wr_byte(next_r, r.ptr, r.w_d[7:0]);
            next_r.ptr = r.ptr + 10'h001;
          end
        end
        OFS_STAT: begin
        end
        default: begin
          next_r.bresp = RESP_SLVERR;
        end
      endcase
    end
    next_r.awready = !next_r.aw_h;
    next_r.wready  = !next_r.w_h;

    // read channel; only PTR and DATA reads see a write of this cycle
    if (s_axi_rvalid && s_axi_rready) begin
      next_r.rvalid  = 1'b0;
      next_r.arready = 1'b1;
    end
    if (s_axi_arvalid && r.arready) begin
      next_r.arready = 1'b0;
      next_r.rvalid  = 1'b1;
      next_r.rresp   = RESP_OKAY;
      next_r.rdata   = 32'h00000000;
      unique case ({s_axi_araddr[11:2], 2'b00})
        OFS_CTRL:  next_r.rdata = {21'h0, r.lines_m1, 2'b00, r.expo,
                                   r.dly_en, r.phase_en, r.slow, r.mode};
        OFS_LEVEL: next_r.rdata = {21'h0, r.maxc, r.glb};
        OFS_COLOR: next_r.rdata = {8'h0, 1'b0, r.cc[2], 1'b0, r.cc[1],
                                   1'b0, r.cc[0]};
        OFS_GROUP: next_r.rdata = {8'h0, r.gdu[2], r.gdu[1], r.gdu[0]};
        OFS_PTR:   next_r.rdata = {22'h0, next_r.ptr};
        OFS_DATA: begin
          next_r.rdata = {24'h0, rd_byte(next_r, next_r.ptr)};
          next_r.ptr   = next_r.ptr + 10'h001;
        end
        OFS_STAT:  next_r.rdata = {13'h0, r.line, r.frames};
        default:   next_r.rresp = RESP_SLVERR;
      endcase
    end

    // frame pulse latches held duty data in framed modes
    next_r.sync_d = frame_sync;
    if (frame_sync && !r.sync_d) begin
      next_r.frames = r.frames + 16'h0001;
      unique case (lmd_mode_t'(r.mode))
        LMD_MODE_FR8, LMD_MODE_FR16: begin
          next_r.disp8  = r.duty8;
          next_r.disp16 = r.duty16;
        end
        LMD_MODE_OFF, LMD_MODE_IMM: begin
        end
      endcase
    end

    // internal oscillator from a fractional accumulator
    if (r.acc + OSC_STEP >= OSC_MOD) begin
      next_r.acc = r.acc + OSC_STEP - OSC_MOD;
      tk         = 1'b1;
    end else begin
      next_r.acc = r.acc + OSC_STEP;
    end

    // line slot: pwm window, blank, and room for two phase steps
    pwm_tk  = r.slow ? PWM_TK_SLOW : PWM_TK_FAST;
    line_tk = pwm_tk + BLANK_TK + (r.phase_en ? 10'(2 * PHASE_TK) : 10'h000);
    if (tk) begin
      if (r.tick >= line_tk - 10'h001) begin
        next_r.tick = 10'h000;
        next_r.line = (r.line >= r.lines_m1) ? 3'h0 : r.line + 3'h1;
      end else begin
        next_r.tick = r.tick + 10'h001;
      end
    end
    next_r.line_on = '0;
    if (r.tick < line_tk - BLANK_TK) begin
      next_r.line_on[r.line] = 1'b1;
    end

    // per-sink duty compare and current gain on the scanned line
    for (int s = 0; s < NSINK; s++) begin
      idx = int'(r.line) * NSINK + s;
      unique case (lmd_mode_t'(r.mode))
        LMD_MODE_IMM, LMD_MODE_OFF: d8 = r.duty8[idx];
        LMD_MODE_FR8, LMD_MODE_FR16: d8 = r.disp8[idx];
      endcase
      if (lmd_mode_t'(r.mode) == LMD_MODE_FR16) begin
        ind = r.disp16[idx];
      end else begin
        ind = {d8, d8};
      end
      if (r.gsel[idx] == 2'b00) begin
        grp = 8'hFF;
      end else begin
        grp = r.gdu[r.gsel[idx] - 2'b01];
      end
      fin = duty_final(ind, grp, r.glb);
      if (r.expo) begin
        fin = expo_curve(fin);
      end
      scaled = 26'(fin) * 26'(pwm_tk);
      thr    = scaled[25:16];
      start  = (r.dly_en ? (r.slow ? DLY_TK_SLOW : DLY_TK_FAST) : 10'h000)
             + (r.phase_en ? 10'((s % 3) * PHASE_TK) : 10'h000);
      next_r.sink_on[s] = r.onoff[idx] && next_r.line_on[r.line]
                       && r.tick >= start && r.tick < start + thr;
      next_r.sgain[s] = 15'(r.cc[s % 3]) * 15'(r.dgain[idx]);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      r <= RST_STATE;
    end else if (ce) begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign s_axi_awready = r.awready;
  assign s_axi_wready  = r.wready;
  assign s_axi_bvalid  = r.bvalid;
  assign s_axi_bresp   = r.bresp;
  assign s_axi_arready = r.arready;
  assign s_axi_rvalid  = r.rvalid;
  assign s_axi_rdata   = r.rdata;
  assign s_axi_rresp   = r.rresp;
  assign line_on       = r.line_on;
  assign sink_on       = r.sink_on;
  assign sink_gain     = r.sgain;
  assign max_current   = r.maxc;
endmodule : lmd_core

// File: testbench/lmd_host_model.sv
// host side of the dimming core: frame pulse source
// assumes fire is a one-cycle request from the bench
module lmd_host_model #(
  parameter int SYNC_H = 8
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic fire,
  output logic      frame_sync
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  ////////////////////////////////////////
  // pulse held for several clocks, low between frames
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt        <= 0;
      frame_sync <= 1'b0;
    end else if (fire) begin
      cnt        <= SYNC_H;
      frame_sync <= 1'b1;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else begin
      cnt        <= 0;
      frame_sync <= 1'b0;
    end
  end
endmodule : lmd_host_model

// File: testbench/lmd_core_checker.sv
// port assertions of the matrix dimming core
// assumes one clock domain and an active-low reset
module lmd_core_checker (
  input wire logic                    clk_sys,
  input wire logic                    rst_n,
  input wire logic                    frame_sync,
  input wire logic                    s_axi_awvalid,
  input wire logic                    s_axi_awready,
  input wire logic                    s_axi_wvalid,
  input wire logic                    s_axi_wready,
  input wire logic                    s_axi_bvalid,
  input wire logic                    s_axi_bready,
  input wire logic                    s_axi_arvalid,
  input wire logic                    s_axi_arready,
  input wire logic                    s_axi_rvalid,
  input wire logic                    s_axi_rready,
  input wire logic [lmd_pkg::NLINE-1:0] line_on,
  input wire logic [2:0]              max_current
);
  import lmd_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  AST_LINE_ONEHOT: assert property ($onehot0(line_on))
    else $error("several scan lines on");
  AST_MAXC_BY_WRITE: assert property ($changed(max_current) |->
    s_axi_bvalid || $past(s_axi_bvalid)) else $error("max current moved");
  AST_WR_ANSWER: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##1 !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer late");
  AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read answer late");
  AST_B_ONCE: assert property (s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid) else $error("write answer repeated");
  AST_R_ONCE: assert property (s_axi_rvalid && s_axi_rready
    |=> !s_axi_rvalid) else $error("read answer repeated");
  AST_AW_BLOCKED: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> !s_axi_awready && !s_axi_wready)
    else $error("write slot open");
  AST_AR_BLOCKED: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read slot open");
  COV_WRITE: cover property (s_axi_bvalid && s_axi_bready);
  COV_READ: cover property (s_axi_rvalid && s_axi_rready);
  COV_FRAME: cover property ($rose(frame_sync));
endmodule : lmd_core_checker

bind lmd_core lmd_core_checker i_lmd_core_checker (
  .clk_sys(clk_sys), .rst_n(rst_n), .frame_sync(frame_sync),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .line_on(line_on), .max_current(max_current)
);

// File: testbench/lmd_core_tb.sv
// self-checking bench of the matrix dimming core
// assumes the host model makes the frame pulses
module lmd_core_tb;
  import lmd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic                clk_sys, rst_n, ce, fire, frame_sync;
  logic [11:0]         awaddr, araddr;
  logic [31:0]         wdata, rdata, rd;
  logic [3:0]          wstrb;
  logic                awvalid, wvalid, bready, arvalid, rready;
  logic                awready, wready, bvalid, arready, rvalid;
  logic [1:0]          bresp, rresp, lit;
  logic [NLINE-1:0]    line_on;
  logic [NSINK-1:0]    sink_on;
  logic [NSINK*15-1:0] sink_gain;
  logic [2:0]          max_current;
  int                  bad_count, checks_done;
  lmd_core i_lmd_core (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
    .frame_sync(frame_sync), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .line_on(line_on), .sink_on(sink_on),
    .sink_gain(sink_gain), .max_current(max_current));
  lmd_host_model i_lmd_host_model (.clk_sys(clk_sys), .rst_n(rst_n),
    .fire(fire), .frame_sync(frame_sync));
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    bit ka, kw;
    int n;
    ka = 0;
    kw = 0;
    n = 0;
    @(posedge clk_sys);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (awready === 1'b1 && !ka) begin
        ka = 1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1 && !kw) begin
        kw = 1;
        wvalid <= 1'b0;
      end
    end while (!(ka && kw && bvalid === 1'b1) && n < 500);
    bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask : wr
  task automatic rdw(input logic [11:0] a, input logic [1:0] er,
                     output logic [31:0] d);
    bit ka;
    int n;
    ka = 0;
    n = 0;
    @(posedge clk_sys);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (arready === 1'b1 && !ka) begin
        ka = 1;
        arvalid <= 1'b0;
      end
    end while (!(ka && rvalid === 1'b1) && n < 500);
    d = rdata;
    rready <= 1'b0;
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask : rdw
  task automatic mw(input logic [9:0] p, input logic [7:0] b);
    wr(OFS_PTR, {22'h0, p}, RESP_OKAY);
    wr(OFS_DATA, {24'h0, b}, RESP_OKAY);
  endtask : mw
  // one line_on window of line 0, blank excluded: which of sinks 0 and 1 ever lit
  task automatic obs(input string nm, input logic [1:0] e);
    int n;
    n = 0;
    lit = 2'b00;
    while (line_on[0] !== 1'b0 && n < 5000) begin
      @(posedge clk_sys);
      n++;
    end
    while (line_on[0] !== 1'b1 && n < 5000) begin
      @(posedge clk_sys);
      n++;
    end
    while (line_on[0] === 1'b1 && n < 9000) begin
      lit = lit | sink_on[1:0];
      @(posedge clk_sys);
      n++;
    end
    chk(nm, {30'h0, e}, {30'h0, lit});
  endtask : obs
  task automatic pulse;
    @(posedge clk_sys);
    fire <= 1'b1;
    @(posedge clk_sys);
    fire <= 1'b0;
    repeat (12) @(posedge clk_sys);
  endtask : pulse
  ////////////////////////////////////////
  task automatic t_reset;
    chk("max_current", 32'h3, {29'h0, max_current});
    rdw(OFS_CTRL, RESP_OKAY, rd);
    chk("ctrl", 32'h0000_0501, rd);
    rdw(OFS_LEVEL, RESP_OKAY, rd);
    chk("level", 32'h0000_03FF, rd);
    rdw(OFS_COLOR, RESP_OKAY, rd);
    chk("color", 32'h0040_4040, rd);
    rdw(OFS_GROUP, RESP_OKAY, rd);
    chk("group", 32'h00FF_FFFF, rd);
    wr(OFS_PTR, 32'h0, RESP_OKAY);
    rdw(OFS_DATA, RESP_OKAY, rd);
    chk("dot_gain", 32'h80, rd);
    rdw(12'h01C, RESP_SLVERR, rd);
    wr(12'h01C, 32'h0, RESP_SLVERR);
  endtask : t_reset
  task automatic t_sram;
    mw(D8_BASE, 8'h5A);
    wr(OFS_DATA, 32'hA5, RESP_OKAY);
    wr(OFS_PTR, {22'h0, D8_BASE}, RESP_OKAY);
    rdw(OFS_DATA, RESP_OKAY, rd);
    chk("byte0", 32'h5A, rd);
    rdw(OFS_DATA, RESP_OKAY, rd);
    chk("byte1", 32'hA5, rd);
    wr(OFS_PTR, {22'h0, D16_BASE}, RESP_OKAY);
    rdw(OFS_DATA, RESP_OKAY, rd);
    chk("duty16", 32'h0, rd);
  endtask : t_sram
  task automatic t_gain;
    wr(OFS_CTRL, 32'h1, RESP_OKAY);
    wr(OFS_COLOR, 32'h0000_017F, RESP_OKAY);
    mw(GAIN_BASE, 8'hFF);
    wr(OFS_DATA, 32'hFF, RESP_OKAY);
    wr(OFS_DATA, 32'hFF, RESP_OKAY);
    obs("dark", 2'b00);
    while (line_on[0] !== 1'b1) @(posedge clk_sys);
    repeat (4) @(posedge clk_sys);
    chk("gain0", 32'h7E81, {17'h0, sink_gain[14:0]});
    chk("gain1", 32'hFF, {17'h0, sink_gain[29:15]});
    chk("gain2", 32'h0, {17'h0, sink_gain[44:30]});
    chk("gain3", 32'h3F80, {17'h0, sink_gain[59:45]});
  endtask : t_gain
  task automatic t_scale;
    mw(D8_BASE, 8'hFF);
    wr(OFS_DATA, 32'hFF, RESP_OKAY);
    mw(ONOFF_BASE, 8'h01);
    obs("mode1", 2'b01);
    wr(OFS_GROUP, 32'h0, RESP_OKAY);
    for (int c = 0; c < 4; c++) begin
      mw(GSEL_BASE, 8'(c));
      obs("group", c == 0 ? 2'b01 : 2'b00);
    end
    mw(GSEL_BASE, 8'h00);
    obs("ungrouped", 2'b01);
    wr(OFS_LEVEL, 32'h0000_0500, RESP_OKAY);
    obs("global", 2'b00);
    chk("max_current", 32'h5, {29'h0, max_current});
    wr(OFS_LEVEL, 32'h0000_03FF, RESP_OKAY);
  endtask : t_scale
  task automatic t_frame;
    wr(OFS_CTRL, 32'h2, RESP_OKAY);
    obs("held", 2'b00);
    pulse;
    obs("frame", 2'b01);
    mw(D8_BASE, 8'h00);
    obs("kept", 2'b01);
    pulse;
    obs("cleared", 2'b00);
    mw(D16_BASE, 8'hFF);
    wr(OFS_DATA, 32'hFF, RESP_OKAY);
    wr(OFS_CTRL, 32'h23, RESP_OKAY);
    pulse;
    obs("mode3", 2'b01);
  endtask : t_frame
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done
  ////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial begin
    #400000;
    bad_count++;
    test_done;
  end
  initial begin
    {rst_n, fire, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    ce = 1'b1;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset;
    t_sram;
    t_gain;
    t_scale;
    t_frame;
    test_done;
  end
endmodule : lmd_core_tb
